//--- core/adc_device.sv
module adc_device #(
  parameter int unsigned conv_cycles = adc_pkg::conv_cycles,
  parameter int unsigned por_cycles = adc_pkg::por_cycles
) (
  input wire logic clock,
  input wire logic rst_n,
  adc_link_if.device link,
  input wire logic signed [17:0] analog_sample,
  output logic low_power,
  output logic converting,
  output logic [15:0] held_result
);
  typedef enum logic [3:0] {
    st_reset = 4'h1,
    st_convert = 4'h2,
    st_sleep = 4'h4,
    st_output = 4'h8
  } state_e;

  state_e state_r;
  state_e state_nxt;
  logic [1:0] sel_sync_r;
  logic [1:0] clk_sync_r;
  logic sel_d_r;
  logic clk_d_r;
  logic sel_rise;
  logic clk_fall;
  logic both_low;
  logic timer_done;
  logic last_bit;
  logic [31:0] timer_r;
  logic [15:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic out_r;
  logic out_nxt;

  // analog front end spans below zero and above full scale
  function automatic logic [15:0] saturate(input logic signed [17:0] v);
    if (v < 0)
      return 16'h0000;
    else if (v > 18'sh0ffff)
      return adc_pkg::code_max;
    else
      return v[15:0];
  endfunction

  // first stage read only by the second
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_sync_r <= 2'h3;
      clk_sync_r <= 2'h3;
      sel_d_r <= 1'b1;
      clk_d_r <= 1'b1;
    end
    else
    begin
      sel_sync_r <= {sel_sync_r[0], link.select_n};
      clk_sync_r <= {clk_sync_r[0], link.shift_clk};
      sel_d_r <= sel_sync_r[1];
      clk_d_r <= clk_sync_r[1];
    end
  end

  assign sel_rise = sel_sync_r[1] && !sel_d_r;
  assign clk_fall = !clk_sync_r[1] && clk_d_r;
  assign both_low = !sel_sync_r[1] && !clk_sync_r[1];
  assign last_bit = (bit_cnt_r == 5'h0f);
  assign timer_done = (state_r == st_reset) ? (timer_r >= por_cycles - 1)
    : (timer_r >= conv_cycles - 1);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= st_reset;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_reset:
      begin
        if (timer_done)
          state_nxt = st_convert;
      end
      st_convert:
      begin
        // host pins ignored: nothing cuts a conversion short
        if (timer_done)
          state_nxt = st_sleep;
      end
      st_sleep:
      begin
        if (both_low)
          state_nxt = st_output;
      end
      st_output:
      begin
        if (sel_rise)
          state_nxt = st_convert;
        else if (clk_fall && last_bit)
          state_nxt = st_convert;
      end
      default:
      begin
        state_nxt = st_reset;
      end
    endcase
  end

  // one timer serves the reset hold and the conversion, never both at once
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_r <= '0;
    end
    else if (state_nxt != state_r)
    begin
      timer_r <= '0;
    end
    else if (state_r == st_reset || state_r == st_convert)
    begin
      timer_r <= timer_r + 32'h00000001;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      held_result <= adc_pkg::result_reset;
    end
    else if (state_r == st_convert && state_nxt == st_sleep)
    begin
      held_result <= saturate(analog_sample);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_r <= adc_pkg::result_reset;
      bit_cnt_r <= '0;
    end
    else if (state_r == st_sleep)
    begin
      // reloaded each sleeping cycle: the held word never moves meanwhile
      shift_r <= held_result;
      bit_cnt_r <= '0;
    end
    else if (state_r == st_output && clk_fall)
    begin
      shift_r <= {shift_r[14:0], 1'b0};
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // built from next state so the registered line keeps the msb-on-entry timing
  always_comb
  begin
    if (state_nxt == st_output && state_r == st_sleep)
      out_nxt = held_result[15];
    else if (state_nxt == st_output)
      out_nxt = clk_fall ? shift_r[14] : shift_r[15];
    else
      out_nxt = (state_nxt != st_sleep);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_r <= 1'b1;
    end
    else
    begin
      out_r <= out_nxt;
    end
  end

  assign link.serial_out_line = out_r;
  assign link.serial_out_oe = !sel_sync_r[1];
  assign low_power = (state_r == st_sleep) && sel_sync_r[1];
  assign converting = (state_r == st_convert) || (state_r == st_reset);
endmodule

//--- common/adc_pkg.sv
package adc_pkg;
  localparam int unsigned clock_hz = 125000000;
  localparam int unsigned result_w = 16;
  // conversion time in microseconds, nominal
  localparam int unsigned conv_time_us = 16600;
  localparam int unsigned conv_cycles = conv_time_us * (clock_hz / 1000000);
  // internal power-on reset hold, microseconds
  localparam int unsigned por_time_us = 500;
  localparam int unsigned por_cycles = por_time_us * (clock_hz / 1000000);
  // host waits the maximum conversion time before a read
  localparam int unsigned wait_time_us = 21000;
  localparam int unsigned wait_cycles = wait_time_us * (clock_hz / 1000000);
  // host shift clock half period in system cycles (80 ns period)
  localparam int unsigned sclk_half_cycles = 5;
  localparam logic [15:0] result_reset = 16'h0000;
  localparam logic [15:0] code_max = 16'hffff;
  localparam int unsigned fifo_depth = 32;
endpackage

//--- common/adc_link_if.sv
interface adc_link_if;
  logic select_n;
  logic shift_clk;
  logic serial_out_line;
  logic serial_out_oe;
  modport device (
    input select_n,
    input shift_clk,
    output serial_out_line,
    output serial_out_oe
  );
  modport host (
    output select_n,
    output shift_clk,
    input serial_out_line,
    input serial_out_oe
  );
endinterface

//--- core/sample_fifo.sv
module sample_fifo #(
  parameter int unsigned width = 16,
  parameter int unsigned depth = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int unsigned aw = $clog2(depth);
  logic [width-1:0] mem_r [depth];
  logic [aw-1:0] wr_r;
  logic [aw-1:0] rd_r;
  logic [aw:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (aw + 1)'(depth));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_r <= (wr_r == aw'(depth - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop)
      begin
        rd_r <= (rd_r == aw'(depth - 1)) ? '0 : rd_r + 1'b1;
      end
      count_r <= count_r + (aw + 1)'(push) - (aw + 1)'(pop);
    end
  end
endmodule

//--- core/adc_host.sv
module adc_host #(
  parameter int unsigned wait_cycles = adc_pkg::wait_cycles,
  parameter int unsigned fifo_depth = adc_pkg::fifo_depth
) (
  input wire logic clock,
  input wire logic rst_n,
  adc_link_if.host link,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data
);
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_wait = 4'h2,
    st_shift = 4'h4,
    st_done = 4'h8
  } state_e;

  state_e state_r;
  logic [31:0] timer_r;
  logic [2:0] div_r;
  logic [4:0] bits_r;
  logic [15:0] data_r;
  logic [1:0] sdo_sync_r;
  logic sel_n_r;
  logic sck_r;
  logic push_r;
  logic take_r;
  logic in_ready;
  logic tick;

  assign tick = (div_r == 3'(adc_pkg::sclk_half_cycles - 1));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sdo_sync_r <= 2'h0;
    else
      sdo_sync_r <= {sdo_sync_r[0], link.serial_out_line};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= '0;
    else if (tick || state_r != st_shift)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= st_idle;
      timer_r <= '0;
      bits_r <= '0;
      data_r <= '0;
      sel_n_r <= 1'b1;
      sck_r <= 1'b1;
      push_r <= 1'b0;
      take_r <= 1'b0;
    end
    else
    begin
      if (push_r && in_ready)
        push_r <= 1'b0;
      take_r <= 1'b0;
      // line reaches the synchroniser output on the rise edge, so it is taken one cycle later
      if (take_r)
        data_r <= {data_r[14:0], sdo_sync_r[1]};
      case (state_r)
        st_idle:
        begin
          // a word still waiting on a full fifo stalls new reads
          if (start && !push_r)
          begin
            timer_r <= '0;
            state_r <= st_wait;
          end
        end
        st_wait:
        begin
          if (timer_r >= wait_cycles - 1)
          begin
            sel_n_r <= 1'b0;
            sck_r <= 1'b0;
            bits_r <= '0;
            state_r <= st_shift;
          end
          else
          begin
            timer_r <= timer_r + 1;
          end
        end
        st_shift:
        begin
          if (abort)
          begin
            sel_n_r <= 1'b1;
            sck_r <= 1'b1;
            state_r <= st_idle;
          end
          else if (tick)
          begin
            sck_r <= !sck_r;
            if (!sck_r)
            begin
              take_r <= 1'b1;
              bits_r <= bits_r + 1'b1;
            end
            else if (bits_r == 5'd16)
            begin
              state_r <= st_done; // falling edge sixteen ends readout
            end
          end
        end
        st_done:
        begin
          sel_n_r <= 1'b1;
          sck_r <= 1'b1;
          push_r <= 1'b1;
          state_r <= st_idle;
        end
        default:
        begin
          state_r <= st_idle;
        end
      endcase
    end
  end

  assign link.select_n = sel_n_r;
  assign link.shift_clk = sck_r;
  assign busy = (state_r != st_idle);

  sample_fifo #(
    .width(16),
    .depth(fifo_depth)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push_r),
    .in_ready(in_ready),
    .in_data(data_r),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
endmodule

//--- bench/adc_conversion_serial_readout_monitor.sv
module adc_conversion_serial_readout_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic shift_clk,
  input wire logic serial_out_line,
  input wire logic serial_out_oe
);
  logic [3:0] sck_r;
  logic [3:0] sel_r;
  logic [4:0] falls_r;
  logic [8:0] low_r;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      sck_r <= 4'hf;
      sel_r <= 4'hf;
    end
    else
    begin
      sck_r <= {sck_r[2:0], shift_clk};
      sel_r <= {sel_r[2:0], select_n};
    end
  // saturating, so a runaway host cannot wrap the count back into range
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      falls_r <= 5'h00;
    else if (select_n)
      falls_r <= 5'h00;
    else if (!sel_r[0] && sck_r[0] && !shift_clk && falls_r != 5'h1f)
      falls_r <= falls_r + 5'h01;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      low_r <= 9'h000;
    else if (select_n)
      low_r <= 9'h000;
    else if (low_r != 9'h1ff)
      low_r <= low_r + 9'h001;
  chk_oe_follows_sel: assert property ($fell(select_n) |-> ##[1:3] serial_out_oe)
    else $error("output not enabled after select fell");
  chk_oe_held_low: assert property ((!select_n) [*3] |-> serial_out_oe)
    else $error("output released while select low");
  chk_oe_off_high: assert property (select_n [*3] |-> !serial_out_oe)
    else $error("output driven while select high");
  chk_oe_cause: assert property ($rose(serial_out_oe) |-> !$past(select_n))
    else $error("output enabled without select");
  // sync latency is at most four cycles, so a clock high that long means no pending fall
  chk_bit_stands: assert property ((&sck_r) && sel_r == 4'h0 && !select_n
    && shift_clk |-> $stable(serial_out_line))
    else $error("serial bit changed without a clock fall");
  chk_bit_on_fall: assert property ($changed(serial_out_line) && !select_n
    && sel_r == 4'h0 |-> !(sck_r[1] && sck_r[2]))
    else $error("serial bit changed long after last fall");
  // the fall that opens the read comes with select and is not counted
  chk_fall_limit: assert property (falls_r <= 5'h10)
    else $error("more than sixteen clock falls in one read");
  chk_read_bounded: assert property (low_r < 9'h12c)
    else $error("select held low too long");
endmodule

//--- bench/tb_adc_conversion_serial_readout.sv
module tb_adc_conversion_serial_readout;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic abort = 1'b0;
  logic out_ready = 1'b0;
  logic signed [17:0] analog_sample = -18'sd5;
  logic busy, out_valid, low_power, converting;
  logic [15:0] out_data, held_result;
  logic [15:0] exp_q[$];
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  adc_link_if lk();
  adc_device #(.conv_cycles(200), .por_cycles(20)) u_adc_device (.clock(clock),
    .rst_n(rst_n), .link(lk.device), .analog_sample(analog_sample), .low_power(low_power),
    .converting(converting), .held_result(held_result));
  adc_host #(.wait_cycles(300), .fifo_depth(32)) u_adc_host (.clock(clock), .rst_n(rst_n),
    .link(lk.host), .start(start), .abort(abort), .busy(busy), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  adc_conversion_serial_readout_monitor u_adc_conversion_serial_readout_monitor (
    .clock(clock), .rst_n(rst_n), .select_n(lk.select_n), .shift_clk(lk.shift_clk),
    .serial_out_line(lk.serial_out_line), .serial_out_oe(lk.serial_out_oe));
  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      error_cnt++;
      results();
    end
  end
  function automatic logic [15:0] sat(input logic signed [17:0] s);
    return s < 0 ? 16'h0000 : (s > 18'sd65535 ? 16'hffff : s[15:0]);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want)
    begin
      error_cnt++;
      $display("unexpected %0t: got %h want %h", $time, got, want);
    end
  endtask
  // one full read; the word pushed is the conversion of the sample set before it
  task automatic read_go(input logic signed [17:0] nxt);
    exp_q.push_back(sat(analog_sample));
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (int k = 0; k < 1000 && busy !== 1'b0; k++) tick(1);
    // device sees the last fall through its synchroniser one cycle after the host idles
    tick(4);
    cmp({15'h0, busy}, 16'h0000);
    cmp(held_result, exp_q[$]);
    cmp({15'h0, converting}, 16'h0001);
    analog_sample = nxt;
  endtask
  task automatic drain(input int n);
    repeat (n)
    begin
      cmp({15'h0, out_valid}, 16'h0001);
      cmp(out_data, exp_q.pop_front());
      out_ready = 1'b1;
      tick(1);
      out_ready = 1'b0;
      tick(1);
    end
    cmp({15'h0, out_valid}, 16'h0000);
  endtask
  task automatic t_power_up;
    cmp({15'h0, converting}, 16'h0001);
    cmp(held_result, adc_pkg::result_reset);
    tick(250);
    cmp({15'h0, converting}, 16'h0000);
    cmp({15'h0, low_power}, 16'h0001);
  endtask
  task automatic t_codes;
    read_go(18'sd70000);
    drain(1);
    read_go(18'sh0a5c3);
    drain(1);
    read_go(18'sd1);
    drain(1);
    read_go(18'sd65535);
    drain(1);
  endtask
  // abort mid-shift: nothing may reach the fifo, the next read sees a fresh conversion
  task automatic t_abort;
    analog_sample = 18'sh08000;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (int k = 0; k < 1000 && lk.select_n !== 1'b0; k++) tick(1);
    tick(40);
    abort = 1'b1;
    tick(1);
    abort = 1'b0;
    for (int k = 0; k < 20 && lk.select_n !== 1'b1; k++) tick(1);
    cmp({15'h0, lk.select_n}, 16'h0001);
    tick(4);
    cmp({15'h0, converting}, 16'h0001);
    cmp({15'h0, out_valid}, 16'h0000);
    read_go(18'sd0);
    drain(1);
  endtask
  task automatic t_fifo;
    for (int i = 0; i < 32; i++) read_go(18'(i * 2047 + 3));
    drain(32);
  endtask
  task automatic results;
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    tick(12);
    rst_n = 1'b1;
    t_power_up();
    t_codes();
    t_abort();
    t_fifo();
    results();
  end
endmodule
